// *** pkg/stc_map.svh ***
`ifndef STC_MAP_SVH
`define STC_MAP_SVH

// ****************************************************************
// Register offsets on the register bus (byte addresses).
// ****************************************************************
`define STC_REG_CTRL 12'h000
`define STC_REG_STAT 12'h004
`define STC_CTRL_RST 16'h1770

// ****************************************************************
// Translator positions and winding level codes.
// ****************************************************************
`define STC_HOME_POS 3'h1
`define STC_LVL_ZERO 2'h0
`define STC_LVL_DIAG 2'h1
`define STC_LVL_FULL 2'h2

// ****************************************************************
// Bridge gate patterns: src_a, snk_a, src_b, snk_b.
// ****************************************************************
`define STC_GATE_OFF 4'h0
`define STC_GATE_POS 4'h9
`define STC_GATE_NEG 4'h6
`define STC_SLOW_POS 4'h1
`define STC_SLOW_NEG 4'h4

// ****************************************************************
// Timing, at a 200 MHz clock.
// ****************************************************************
`define STC_CLK_MHZ 200
`define STC_BLANK_NS 1000
`define STC_BLANK_CYC ((`STC_BLANK_NS * `STC_CLK_MHZ) / 1000)
`define STC_OFF_DEF_US 30
`define STC_OFF_DEF_CYC (`STC_OFF_DEF_US * `STC_CLK_MHZ)
`define STC_OSC_OHM_PER_US 825
`define STC_FAST_NUM 5
`define STC_FAST_SHIFT 4

`endif

// *** pkg/stc_pkg.sv ***
package stc_pkg;

  // ****************************************************************
  // Chopper states, one-hot.
  // ****************************************************************
  typedef enum logic [3:0] {
    CH_IDLE  = 4'h1,
    CH_DRIVE = 4'h2,
    CH_FAST  = 4'h4,
    CH_SLOW  = 4'h8
  } stc_chop_t;

  // Per-bridge chopper state.
  typedef struct packed {
    stc_chop_t st;
    logic [15:0] off_cnt;
    logic [15:0] fast_cnt;
    logic [7:0] blank_cnt;
  } stc_bridge_t;

  // Demand for one winding.
  typedef struct packed {
    logic [1:0] level;
    logic neg;
    logic mixed;
  } stc_wind_t;

  // APB request and answer.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } stc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } stc_apb_rsp_t;

  // Whole state of the block.
  typedef struct packed {
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic step_prev;
    logic [2:0] pos;
    stc_wind_t [1:0] wind;
    stc_bridge_t [1:0] br;
    logic [1:0][3:0] gate;
    logic [15:0] off_cfg;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } stc_state_t;

endpackage

// *** src/stc_translator.sv ***
// Operation
// - Each rising step edge advances the position one increment.
// - Size select low gives full steps, high gives half steps.
// - Direction low sequences clockwise, high counterclockwise.
// - Direction change alone never moves the position.
// - Reset returns to Home with both bridges in mixed decay.
// - While reset is low, hold Home and switch off all transistors.
// - Step edges during reset are ignored.
// - Falling level selects mixed decay; equal or rising selects slow.
// - Translator sets magnitude code and current direction per winding.
// - Each bridge has its own fixed off-time current loop.
// - Drive a diagonal pair; comparator trip ends the on phase.
// - Slow decay drops the source; mixed drops source and sink.
// - Off-time comes from the timing setting, resistance over 825; the code takes it in clock cycles from CTRL.
// - Timing pin tied high gives a 30 microsecond off-time.
// - Comparator is ignored about one microsecond after switching.
// - Mixed decay is fast for 31.25 percent of off-time, then slow.
// - Eight 45 degree positions; full steps use diagonals; Home 45.
// - Enable high disables bridges; translator keeps running.
`timescale 1ns/10ps
`include "stc_map.svh"

module stc_translator
  import stc_pkg::*;
#(
  parameter logic [15:0] OFF_DEF_CYC = 16'(`STC_OFF_DEF_CYC)
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire stc_apb_req_t apb_req,
  output stc_apb_rsp_t apb_rsp,
  input wire logic step_in,
  input wire logic dir_in,
  input wire logic step_size_select,
  input wire logic reset_in_n,
  input wire logic enable_in_n,
  input wire logic off_time_set_pin,
  input wire logic winding_one_sense,
  input wire logic winding_two_sense,
  output stc_wind_t [1:0] wind_demand,
  output logic [1:0][3:0] bridge_gate
);

  // ****************************************************************
  // Level and polarity of a winding at a position.
  // ****************************************************************

  // Diagonals carry 70.71 percent, the axis of the winding full scale.
  function automatic logic [1:0] stc_level(input logic w,
                                           input logic [2:0] p);
    if (p[0])
      return `STC_LVL_DIAG;
    else if (p[1] == w)
      return `STC_LVL_FULL;
    else
      return `STC_LVL_ZERO;
  endfunction

  // Winding one is negative at 135..225, winding two at 225..315.
  function automatic logic stc_neg(input logic w, input logic [2:0] p);
    if (w)
      return p >= 3'h5;
    else
      return (p >= 3'h3) && (p <= 3'h5);
  endfunction

  // ****************************************************************
  // State and decoded inputs.
  // ****************************************************************
  stc_state_t st_ff;
  stc_state_t nxt_st;
  logic rst_ok;
  logic out_off;
  logic step_go;
  logic apb_setup;
  logic apb_done;
  logic bad_addr;
  logic [15:0] off_val;
  logic [19:0] fast_prod;
  logic [15:0] fast_val;
  logic [1:0] sense;
  logic [31:0] status;

  // Second sync stage feeds the step, reset and enable decoding.
  assign rst_ok = st_ff.sync2[3];
  assign out_off = st_ff.sync2[4];
  assign step_go = rst_ok & st_ff.sync2[0] & ~st_ff.step_prev;
  assign sense = {winding_two_sense, winding_one_sense};

  // Default off-time when the timing pin is tied high.
  assign off_val = off_time_set_pin ? OFF_DEF_CYC : st_ff.off_cfg;
  assign fast_prod = {4'h0, off_val} * 20'(`STC_FAST_NUM);
  assign fast_val = fast_prod[`STC_FAST_SHIFT +: 16];

  // Bus decode helpers.
  assign apb_setup = apb_req.psel & ~apb_req.penable;
  assign apb_done = apb_req.psel & apb_req.penable & st_ff.pready;
  assign bad_addr = (apb_req.paddr != `STC_REG_CTRL) &&
                    (apb_req.paddr != `STC_REG_STAT);
  assign status = {19'h0, ~rst_ok, out_off, st_ff.wind[1],
                   st_ff.wind[0], st_ff.pos};

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************

  // Synchronisers, translator, choppers and the bus slave.
  always_comb
  begin
    logic [2:0] inc;
    inc = 3'h1;
    nxt_st = st_ff;
    // Two-stage synchronisers; stage one is read only by stage two.
    nxt_st.sync1 = {enable_in_n, reset_in_n, step_size_select,
                    dir_in, step_in};
    nxt_st.sync2 = st_ff.sync1;
    // Tracking the step level in reset hides a high step at release.
    nxt_st.step_prev = st_ff.sync2[0];

    // Translator.
    if (!rst_ok)
    begin
      nxt_st.pos = `STC_HOME_POS;
      for (int i = 0; i < 2; i++)
      begin
        nxt_st.wind[i].level = `STC_LVL_DIAG;
        nxt_st.wind[i].neg = 1'b0;
        nxt_st.wind[i].mixed = 1'b1;
      end
    end
    else if (step_go)
    begin
      // Full steps from an axis position land on the next diagonal.
      if (!st_ff.sync2[2] && st_ff.pos[0])
        inc = 3'h2;
      if (st_ff.sync2[1])
        nxt_st.pos = st_ff.pos + inc;
      else
        nxt_st.pos = st_ff.pos - inc;
      for (int i = 0; i < 2; i++)
      begin
        nxt_st.wind[i].level = stc_level(i[0], nxt_st.pos);
        nxt_st.wind[i].neg = stc_neg(i[0], nxt_st.pos);
        nxt_st.wind[i].mixed =
          nxt_st.wind[i].level < st_ff.wind[i].level;
      end
    end

    // One independent chopper per bridge.
    for (int i = 0; i < 2; i++)
    begin
      if (!rst_ok || out_off ||
          st_ff.wind[i].level == `STC_LVL_ZERO)
      begin
        nxt_st.br[i].st = CH_IDLE;
        nxt_st.gate[i] = `STC_GATE_OFF;
      end
      else
      begin
        case (st_ff.br[i].st)
          CH_IDLE:
          begin
            nxt_st.br[i].st = CH_DRIVE;
            nxt_st.br[i].blank_cnt = 8'(`STC_BLANK_CYC);
            nxt_st.gate[i] = st_ff.wind[i].neg ? `STC_GATE_NEG
                                               : `STC_GATE_POS;
          end
          CH_DRIVE:
          begin
            // Polarity follows the translator; dead time is analog.
            nxt_st.gate[i] = st_ff.wind[i].neg ? `STC_GATE_NEG
                                               : `STC_GATE_POS;
            if (st_ff.br[i].blank_cnt != 8'h0)
              nxt_st.br[i].blank_cnt = st_ff.br[i].blank_cnt - 8'h1;
            else if (sense[i])
            begin
              nxt_st.br[i].off_cnt = off_val;
              if (st_ff.wind[i].mixed && fast_val != 16'h0)
              begin
                nxt_st.br[i].st = CH_FAST;
                nxt_st.br[i].fast_cnt = fast_val;
                nxt_st.gate[i] = `STC_GATE_OFF;
              end
              else
              begin
                nxt_st.br[i].st = CH_SLOW;
                nxt_st.gate[i] = st_ff.wind[i].neg ? `STC_SLOW_NEG
                                                   : `STC_SLOW_POS;
              end
            end
          end
          CH_FAST:
          begin
            nxt_st.br[i].off_cnt = st_ff.br[i].off_cnt - 16'h1;
            nxt_st.br[i].fast_cnt = st_ff.br[i].fast_cnt - 16'h1;
            if (st_ff.br[i].fast_cnt <= 16'h1)
            begin
              nxt_st.br[i].st = CH_SLOW;
              nxt_st.gate[i] = st_ff.wind[i].neg ? `STC_SLOW_NEG
                                                 : `STC_SLOW_POS;
            end
          end
          CH_SLOW:
          begin
            nxt_st.br[i].off_cnt = st_ff.br[i].off_cnt - 16'h1;
            if (st_ff.br[i].off_cnt <= 16'h1)
            begin
              nxt_st.br[i].st = CH_DRIVE;
              nxt_st.br[i].blank_cnt = 8'(`STC_BLANK_CYC);
              nxt_st.gate[i] = st_ff.wind[i].neg ? `STC_GATE_NEG
                                                 : `STC_GATE_POS;
            end
          end
          default:
          begin
            nxt_st.br[i].st = CH_IDLE;
            nxt_st.gate[i] = `STC_GATE_OFF;
          end
        endcase
      end
    end

    // APB slave: answer is prepared in setup, ready in the access cycle.
    nxt_st.pready = apb_setup;
    nxt_st.pslverr = apb_setup & bad_addr;
    nxt_st.prdata = 32'h0;
    if (apb_setup && !apb_req.pwrite)
    begin
      if (apb_req.paddr == `STC_REG_CTRL)
        nxt_st.prdata = {16'h0, st_ff.off_cfg};
      else if (apb_req.paddr == `STC_REG_STAT)
        nxt_st.prdata = status;
    end
    if (apb_done && apb_req.pwrite && apb_req.paddr == `STC_REG_CTRL)
      nxt_st.off_cfg = apb_req.pwdata[15:0];
  end

  // ****************************************************************
  // State register.
  // ****************************************************************

  // Reset gives Home, mixed decay, all bridges off.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '0;
      st_ff.pos <= `STC_HOME_POS;
      st_ff.wind <= {2{`STC_LVL_DIAG, 1'b0, 1'b1}};
      st_ff.br[0].st <= CH_IDLE;
      st_ff.br[1].st <= CH_IDLE;
      st_ff.off_cfg <= `STC_CTRL_RST;
    end
    else
      st_ff <= nxt_st;
  end

  // Outputs straight from the state register.
  assign apb_rsp = {st_ff.prdata, st_ff.pready, st_ff.pslverr};
  assign wind_demand = st_ff.wind;
  assign bridge_gate = st_ff.gate;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_step_moves: assert property (
    step_go |=> st_ff.pos != $past(st_ff.pos))
    else $error("Step edge did not move the position.");

  chk_half_ccw: assert property (
    step_go && st_ff.sync2[2] && st_ff.sync2[1]
      |=> st_ff.pos == $past(st_ff.pos) + 3'h1)
    else $error("Half step counterclockwise went wrong.");

  chk_full_diag: assert property (
    step_go && !st_ff.sync2[2] |=> st_ff.pos[0])
    else $error("Full step left the diagonal positions.");

  chk_dir_hold: assert property (
    rst_ok && !step_go |=> $stable(st_ff.pos))
    else $error("Position moved without a step edge.");

  chk_reset_home: assert property (
    !rst_ok |=> st_ff.pos == `STC_HOME_POS && st_ff.gate == '0
      && st_ff.wind[0].mixed && st_ff.wind[1].mixed)
    else $error("Reset did not hold Home with outputs off.");

  chk_decay_pick: assert property (
    step_go |=> st_ff.wind[0].mixed ==
      (st_ff.wind[0].level < $past(st_ff.wind[0].level)))
    else $error("Decay mode does not follow the level change.");

  chk_enable_off: assert property (
    out_off |=> st_ff.gate == '0 && st_ff.br[0].st == CH_IDLE)
    else $error("Disabled bridge still drives.");

  chk_blank_hold: assert property (
    st_ff.br[0].st == CH_DRIVE && st_ff.br[0].blank_cnt != 8'h0
      |=> st_ff.br[0].st inside {CH_DRIVE, CH_IDLE})
    else $error("Comparator acted during blanking.");

  chk_fast_start: assert property (
    st_ff.br[0].st == CH_DRIVE && $past(st_ff.br[0].st) == CH_DRIVE
      ##1 st_ff.br[0].st == CH_FAST
      |-> st_ff.br[0].fast_cnt == fast_val && st_ff.gate[0] == '0)
    else $error("Mixed decay fast phase started wrongly.");

  chk_slow_gate: assert property (
    st_ff.br[1].st == CH_SLOW && !st_ff.wind[1].neg
      |-> st_ff.gate[1] == `STC_SLOW_POS)
    else $error("Slow decay did not keep only the sink on.");

endmodule

// *** dv/stc_host.sv ***
`timescale 1ns/10ps
// ***************************************************************
// Host controller model: drives step, direction, size and reset.
// ***************************************************************
module stc_host
(
  input wire logic pclk,
  output logic step_in,
  output logic dir_in,
  output logic step_size_select,
  output logic reset_in_n
);
  // One step: settle inputs, then a 1 us high and 1 us low pulse.
  task automatic move(input logic d, input logic s);
    dir_in <= d;
    step_size_select <= s;
    repeat (8) @(posedge pclk);
    step_in <= 1'b1;
    repeat (200) @(posedge pclk);
    step_in <= 1'b0;
    repeat (200) @(posedge pclk);
  endtask

  // Idle pins at time zero, device held in reset.
  initial
  begin
    step_in = 1'b0;
    dir_in = 1'b0;
    step_size_select = 1'b1;
    reset_in_n = 1'b0;
  end
endmodule

// *** dv/stc_translator_tb.sv ***
`timescale 1ns/10ps
module stc_translator_tb import stc_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ena_n = 1'b0;
  logic osc_hi = 1'b1;
  logic [1:0] sense = 2'h0;
  stc_apb_req_t req = '0;
  stc_apb_rsp_t rsp;
  stc_wind_t [1:0] wd;
  logic [1:0][3:0] gate;
  logic step, dir, size, rst_n;
  int n_mismatch = 0;
  int n_checks = 0;
  int pos = 1;
  logic [31:0] rd;
  logic err;

  // Clock at 200 MHz.
  always #2.5 pclk = ~pclk;

  stc_host host_u (.pclk(pclk), .step_in(step), .dir_in(dir),
    .step_size_select(size), .reset_in_n(rst_n));

  stc_translator #(.OFF_DEF_CYC(16'h0028)) dut_u (.pclk(pclk),
    .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .step_in(step),
    .dir_in(dir), .step_size_select(size), .reset_in_n(rst_n),
    .enable_in_n(ena_n), .off_time_set_pin(osc_hi),
    .winding_one_sense(sense[0]), .winding_two_sense(sense[1]),
    .wind_demand(wd), .bridge_gate(gate));

  // ***************************************************************
  // Reporting.
  // ***************************************************************
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Compares one value with its expectation.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Ends the run when a bounded wait ran out.
  task automatic bound(input int n, input int lim);
    if (n >= lim)
    begin
      n_mismatch++;
      print_verdict();
    end
  endtask

  // APB transfer; waits for pready with a bound, then idles one edge.
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int i;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (rsp.pready !== 1'b1 && i < 50);
    bound(i, 50);
    r = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask

  // ***************************************************************
  // Translator model.
  // ***************************************************************
  function automatic int lvl(int p, int w);
    if (p % 2)
      return 1;
    return ((p % 4 == 0) == (w == 0)) ? 2 : 0;
  endfunction

  // Winding one reverses at 135..225, winding two at 225..315.
  function automatic bit ngm(int p, int w);
    return w ? p >= 5 : (p >= 3 && p <= 5);
  endfunction

  // Compares both windings with the model position.
  task automatic chk_wind(input logic [1:0] mx);
    for (int w = 0; w < 2; w++)
    begin
      chk({wd[w].level, wd[w].mixed}, {2'(lvl(pos, w)), mx[w]});
      if (lvl(pos, w) != 0)
        chk(wd[w].neg, ngm(pos, w));
    end
  endtask

  // One step through the host, then model and status compare.
  task automatic stp(input logic d, input logic s);
    int np;
    logic [1:0] mx;
    np = pos + (d ? 1 : -1) * ((s || pos % 2 == 0) ? 1 : 2);
    np = (np + 8) % 8;
    for (int w = 0; w < 2; w++)
      mx[w] = lvl(np, w) < lvl(pos, w);
    host_u.move(d, s);
    pos = np;
    chk_wind(mx);
    // Driven bridges show the diagonal pair of the model polarity.
    for (int w = 0; w < 2; w++)
      chk(gate[w], (lvl(pos, w) == 0 || ena_n) ? 4'h0 :
        (ngm(pos, w) ? 4'h6 : 4'h9));
    apb(1'b0, 12'h004, 32'h0, rd, err);
    chk({rd[12:11], rd[2:0]}, {1'b0, ena_n, 3'(pos)});
  endtask

  // Trip, off-time, fast part and blanking of one bridge.
  task automatic chop(input int b, input bit mx, input int off);
    int n;
    int nz;
    n = 0;
    sense[b] <= 1'b1;
    while (gate[b] !== 4'h9 && n < 400)
    begin
      @(posedge pclk);
      n++;
    end
    bound(n, 400);
    n = 0;
    while (gate[b] === 4'h9 && n < 400)
    begin
      @(posedge pclk);
      n++;
    end
    bound(n, 400);
    sense[b] <= 1'b0;
    chk(gate[b], mx ? 4'h0 : 4'h1);
    n = 0;
    nz = 0;
    while (gate[b] !== 4'h9 && n < 400)
    begin
      nz += (gate[b] === 4'h0);
      @(posedge pclk);
      n++;
    end
    bound(n, 400);
    chk(n >= off - 2 && n <= off + 1, 1);
    nz -= mx ? (off * 5) >> 4 : 0;
    chk(nz >= -1 && nz <= 1, 1);
    sense[b] <= 1'b1;
    repeat (150) @(posedge pclk);
    chk(gate[b], 4'h9);
    sense[b] <= 1'b0;
  endtask

  // ***************************************************************
  // Main sequence.
  // ***************************************************************
  initial
  begin
    void'($urandom(95));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    host_u.move(1'b1, 1'b1);
    chk_wind(2'h3);
    chk(gate, 8'h00);
    host_u.reset_in_n <= 1'b1;
    repeat (5) @(posedge pclk);
    chk_wind(2'h3);
    apb(1'b0, 12'h000, 32'h0, rd, err);
    chk(rd, 32'h0000_1770);
    apb(1'b0, 12'h008, 32'h0, rd, err);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h000, 32'h0000_0020, rd, err);
    chop(0, 1'b1, 40);
    stp(1'b1, 1'b1);
    osc_hi <= 1'b0;
    chop(1, 1'b0, 32);
    host_u.dir_in <= 1'b0;
    repeat (20) @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0, rd, err);
    chk(rd[2:0], pos);
    stp(1'b0, 1'b0);
    stp(1'b1, 1'b0);
    repeat (14) stp(1'($urandom), 1'($urandom));
    ena_n <= 1'b1;
    stp(1'b0, 1'b1);
    chk(gate, 8'h00);
    ena_n <= 1'b0;
    host_u.reset_in_n <= 1'b0;
    repeat (5) @(posedge pclk);
    pos = 1;
    chk_wind(2'h3);
    chk(gate, 8'h00);
    // A step while the device pin holds reset stays at Home.
    host_u.move(1'b1, 1'b1);
    chk_wind(2'h3);
    host_u.reset_in_n <= 1'b1;
    repeat (5) @(posedge pclk);
    stp(1'b1, 1'b1);
    // Second bus reset in mid-run restores Home and the off-time.
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0, rd, err);
    chk(rd, 32'h0000_1770);
    pos = 1;
    chk_wind(2'h3);
    print_verdict();
  end
endmodule
